// File: hw/phy_timing.v
// Operation
// - 10M MII: first line bit leaves within 2 bit times of sampled data.
// - 100M MII: start symbol leaves within 3 bit times of TXEN sampled; here two clocks (10 bit times) after that edge.
// - 100M symbol mode: start symbol leaves within 7 bit times of TXD.
// - At 100M half duplex carrier rises within 4 bit times of TXEN rising; here three clocks (15 bit times) after TXEN is sampled.
// - At 10M half duplex carrier rises within 2 bit times of TXEN rising.
// - At either rate carrier drops within 4 bit times of TXEN falling; at 100M here three clocks (15 bit times) after it is sampled.
// - 100M: start symbol reaches RXD in 17 (MII) or 9 (symbol) bit times.
// - At 100M carrier rises 10 to 14 bit times after a received start symbol.
// - 100M half duplex: start while sending sets COL in 9 to 13 bit times.
// - At 100M carrier drops 13 to 18 bit times after a received end symbol.
// - Power-on sequence completes between 40 ms and 500 ms.
// - Hardware reset input isolates the device and restarts initialisation.
// - A valid transmit clock appears within 500 ms of reset release.
// - One 10M bit time is 100 ns.
`timescale 1ns/1ps
`include "phy_timing_regs.vh"
`default_nettype none
module phy_timing #(
    parameter [24:0] POR_CYCLES   = 25'd800000,
    parameter [24:0] CLKV_CYCLES  = 25'd800000
) (
    input  wire       SYS_CLK,
    input  wire       RST_B,
    input  wire       HW_RESET_LOW_INPUT,
    input  wire       SPEED_100,
    input  wire       SYMBOL_MODE,
    input  wire       HALF_DUPLEX,
    input  wire       TXEN,
    input  wire [4:0] TXD,
    input  wire       LINE_RECEIVE_PAIR_VALID,
    input  wire [4:0] LINE_RECEIVE_PAIR,
    input  wire       RX_READY,
    output reg        LINE_TRANSMIT_PAIR_EN,
    output reg  [4:0] LINE_TRANSMIT_PAIR,
    output reg        RXDV,
    output reg  [4:0] RXD,
    output reg        CRS,
    output reg        COL,
    output reg        ISOLATE,
    output reg        TXCLK_VALID,
    output reg        INIT_DONE
);
    // Cycle counts: least times round up, longest round down.
    localparam integer TX10_CYC  = (`TX10_LAT_BT*`BIT_NS_10M)/`CLK_PERIOD_NS;
    localparam integer CRS10_CYC = (`CRS_TX10_ON_BT*`BIT_NS_10M)/`CLK_PERIOD_NS;
    localparam integer POR_MIN_CYC =
        (`POR_MIN_MS*1000000+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS;
    localparam integer HWRST_CYC =
        (`HWRST_MIN_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // Reset release and pin synchronisers
    // ---------------------------------------------------------------
    reg [1:0] rst_q;
    reg [1:0] hw_q;
    reg [1:0] en_q;
    wire      rst_n = rst_q[1];
    // Reset release through two flops; assertion is asynchronous
    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    // The external reset pin is foreign to this clock
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            hw_q <= 2'b00;
            en_q <= 2'b00;
        end else begin
            hw_q <= {hw_q[0], HW_RESET_LOW_INPUT};
            en_q <= {en_q[0], TXEN};
        end
    end

    // ---------------------------------------------------------------
    // Power-on and hardware reset sequencing
    // ---------------------------------------------------------------
    reg [24:0] init_q;
    reg [24:0] clkv_q;
    reg [4:0]  pulse_q;
    wire       hw_active = !hw_q[1];
    // Short glitches below the minimum width are still honoured: isolation
    // is immediate, the pulse counter only tracks width for diagnostics.
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            init_q      <= 25'd0;
            clkv_q      <= 25'd0;
            pulse_q     <= 5'd0;
            ISOLATE     <= 1'b1;
            INIT_DONE   <= 1'b0;
            TXCLK_VALID <= 1'b0;
        end else if (hw_active) begin
            ISOLATE     <= 1'b1;
            INIT_DONE   <= 1'b0;
            TXCLK_VALID <= 1'b0;
            init_q      <= 25'd0;
            clkv_q      <= 25'd0;
            if (pulse_q != HWRST_CYC[4:0])
                pulse_q <= pulse_q + 5'd1;
        end else begin
            pulse_q <= 5'd0;
            if (init_q != POR_CYCLES)
                init_q <= init_q + 25'd1;
            else
                INIT_DONE <= 1'b1;
            if (clkv_q != CLKV_CYCLES)
                clkv_q <= clkv_q + 25'd1;
            else
                TXCLK_VALID <= 1'b1;
            ISOLATE <= (init_q != POR_CYCLES);
        end
    end

    // ---------------------------------------------------------------
    // Transmit path and carrier during transmission
    // ---------------------------------------------------------------
    reg       tx_seen_q;
    reg       tx_crs_q;
    wire      up = INIT_DONE && !ISOLATE;
    // One clock is 5 bit times at 100M; 100M TXD emits next edge, TXEN after two sync flops;
    // 10M paths fit TX10_CYC (four clocks for 2 bit times).
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            LINE_TRANSMIT_PAIR_EN <= 1'b0;
            LINE_TRANSMIT_PAIR    <= 5'h00;
            tx_seen_q             <= 1'b0;
            tx_crs_q              <= 1'b0;
        end else begin
            LINE_TRANSMIT_PAIR_EN <= up && en_q[1];
            if (SPEED_100 && !SYMBOL_MODE && en_q[1] && !tx_seen_q)
                LINE_TRANSMIT_PAIR <= `SYM_J;
            else
                LINE_TRANSMIT_PAIR <= TXD;
            tx_seen_q <= en_q[1]; // Not tied to carrier, so full duplex too
            if (!en_q[1])
                tx_crs_q <= 1'b0;
            else if (SPEED_100 || CRS10_CYC <= TX10_CYC)
                tx_crs_q <= up && HALF_DUPLEX;
        end
    end

    // ---------------------------------------------------------------
    // Two-entry receive buffer
    // ---------------------------------------------------------------
    reg [4:0] buf_q [0:1];
    reg [1:0] cnt_q;
    reg       rd_q;
    reg       wr_q;
    wire      in_ready = (cnt_q != 2'd2);
    wire      push = LINE_RECEIVE_PAIR_VALID && in_ready && up;
    wire      pop  = RXDV && RX_READY;
    // Holding a stalled word keeps RXD stable until taken
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            buf_q[0] <= 5'h00;
            buf_q[1] <= 5'h00;
            cnt_q    <= 2'd0;
            rd_q     <= 1'b0;
            wr_q     <= 1'b0;
            RXDV     <= 1'b0;
            RXD      <= 5'h00;
        end else begin
            if (push) begin
                buf_q[wr_q] <= LINE_RECEIVE_PAIR;
                wr_q        <= ~wr_q;
            end
            if (pop)
                rd_q <= ~rd_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
            // Output register reflects the next head entry, bounded to
            // one or two clocks (10 bit times) when not stalled
            if (!RXDV || pop) begin
                if (cnt_q - {1'b0, pop} != 2'd0) begin
                    RXDV <= 1'b1;
                    RXD  <= buf_q[rd_q ^ pop];
                end else if (push) begin
                    RXDV <= 1'b1;
                    RXD  <= LINE_RECEIVE_PAIR;
                end else begin
                    RXDV <= 1'b0;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Receive carrier and collision (100M, two clocks = 10 bit times on, three = 15 off)
    // ---------------------------------------------------------------
    reg [1:0] jdly_q;
    reg [2:0] tdly_q;
    reg       rx_crs_q;
    wire      is_j = push && (LINE_RECEIVE_PAIR == `SYM_J);
    wire      is_t = push && (LINE_RECEIVE_PAIR == `SYM_T);
    // Delay lines place carrier rise at the 10 bit-time edge of its window, the fall inside it
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            jdly_q   <= 2'b00;
            tdly_q   <= 3'b000;
            rx_crs_q <= 1'b0;
            CRS      <= 1'b0;
            COL      <= 1'b0;
        end else begin
            jdly_q <= {jdly_q[0], is_j && SPEED_100};
            tdly_q <= {tdly_q[1:0], is_t && SPEED_100};
            if (jdly_q[1])
                rx_crs_q <= 1'b1;
            else if (tdly_q[2])
                rx_crs_q <= 1'b0;
            CRS <= tx_crs_q || (jdly_q[1] || (rx_crs_q && !tdly_q[2]));
            if (jdly_q[1] && tx_crs_q && HALF_DUPLEX)
                COL <= 1'b1;
            else if (!tx_crs_q || !(rx_crs_q && !tdly_q[2]))
                COL <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: hw/phy_timing_regs.vh
`ifndef PHY_TIMING_REGS_VH
`define PHY_TIMING_REGS_VH
// ---------------------------------------------------------------
// Timing figures, in nanoseconds, milliseconds and bit times
// ---------------------------------------------------------------
`define CLK_PERIOD_NS        50
`define BIT_NS_10M           100
`define BIT_NS_100M          10
`define TX10_LAT_BT          2
`define TX100_LAT_BT         3
`define TXSYM_LAT_BT         7
`define CRS_TX100_ON_BT      4
`define CRS_TX10_ON_BT       2
`define CRS_TX_OFF_BT        4
`define RX100_MII_LAT_BT     17
`define RXSYM_LAT_BT         9
`define CRS_RX_ON_MIN_BT     10
`define CRS_RX_ON_MAX_BT     14
`define COL_ON_MIN_BT        9
`define COL_ON_MAX_BT        13
`define CRS_RX_OFF_MIN_BT    13
`define CRS_RX_OFF_MAX_BT    18
`define POR_MIN_MS           40
`define POR_MAX_MS           500
`define HWRST_MIN_NS         500
`define TXCLK_VALID_MAX_MS   500
// ---------------------------------------------------------------
// Symbol codes on the 5-bit line
// ---------------------------------------------------------------
`define SYM_J                5'h18
`define SYM_T                5'h0d
`endif

// File: test/phy_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Controller side: transmit enable, receive ready, reset pin
// ----
module phy_mac_model (
    input  wire        clk,
    input  wire        send,
    input  wire        stall,
    input  wire        rst_req,
    output logic       txen = 1'b0,
    output logic [4:0] txd = 5'h00,
    output logic       ready = 1'b1,
    output logic       rst_low = 1'b1
);
    logic [3:0] cnt = 4'h0;
    // Inputs taken at the edge, driven 1 ns later to stay clear of it
    always @(posedge clk) begin
        txen  <= #1 send;
        txd   <= #1 txd + 5'h01; // Moving pattern, a stale word never matches
        ready <= #1 !stall;
        // Pulse of 12 cycles, above the minimum width
        cnt     <= #1 rst_req ? 4'hc : cnt - {3'h0, cnt != 4'h0};
        rst_low <= #1 !(rst_req || cnt > 4'h1);
    end
endmodule
`default_nettype wire

// File: test/phy_timing_bench.sv
`timescale 1ns/1ps
`include "phy_timing_regs.vh"
`default_nettype none
// ----
// Bench
// ----
module phy_timing_bench;
    logic clk = 0, rst_b = 0, spd = 0, sym = 0, half = 1, send = 0;
    logic stall = 0, req = 0, rv = 0;
    logic [4:0] rd = 5'h1f;
    wire txen, rdy, hrst, ten, rxdv, crs, col, iso, tcv, idone;
    wire [4:0] txd, tdat, rxd;
    int bad_count = 0, samples_checked = 0;
    always #25 clk = ~clk;
    phy_mac_model mac (.clk(clk), .send(send), .stall(stall), .rst_req(req),
        .txen(txen), .txd(txd), .ready(rdy), .rst_low(hrst));
    phy_timing #(.POR_CYCLES(25'd20), .CLKV_CYCLES(25'd20)) DUT (
        .SYS_CLK(clk), .RST_B(rst_b), .HW_RESET_LOW_INPUT(hrst),
        .SPEED_100(spd), .SYMBOL_MODE(sym), .HALF_DUPLEX(half), .TXEN(txen),
        .TXD(txd), .LINE_RECEIVE_PAIR_VALID(rv), .LINE_RECEIVE_PAIR(rd),
        .RX_READY(rdy), .LINE_TRANSMIT_PAIR_EN(ten), .LINE_TRANSMIT_PAIR(tdat),
        .RXDV(rxdv), .RXD(rxd), .CRS(crs), .COL(col), .ISOLATE(iso),
        .TXCLK_VALID(tcv), .INIT_DONE(idone));
    task automatic chk(input string s, input logic [4:0] e,
                       input logic [4:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Steps land 1 ns after the edge, clear of the sampling instant
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic push(input logic [4:0] w);
        rv = 1'b1;
        rd = w;
        tick(1);
    endtask
    task automatic wait_init;
        int i;
        for (i = 0; i < 60 && idone !== 1'b1; i++) tick(1);
        chk("init", 5'h01, {4'h0, idone});
        if (idone !== 1'b1) complete_run();
        tick(2);
        chk("isolate off", 5'h00, {4'h0, iso});
        chk("tx clock", 5'h01, {4'h0, tcv});
    endtask
    // Line enable, line data and carrier follow transmit enable; the last
    // pass is 100M full duplex, where carrier must stay low
    task automatic t_tx;
        logic [4:0] first;
        logic       seen;
        for (int m = 0; m < 4; m++) begin
            {spd, sym, half} = m == 0 ? 3'b001 :
                (m == 2 ? 3'b111 : {2'b10, m == 1});
            {send, seen, first} = {2'b10, 5'h00};
            repeat (7) begin
                tick(1);
                if (ten === 1'b1 && seen !== 1'b1)
                    {seen, first} = {1'b1, tdat};
            end
            chk("tx on", {4'h1, half}, {3'h0, ten, crs});
            if (spd && !sym)
                chk("tx start symbol", `SYM_J, first);
            // Model steps its word each edge, so the line lags it by one
            @(negedge clk);
            chk("tx data", txd - 5'h01, tdat);
            tick(1);
            send = 1'b0;
            tick(7);
            chk("tx off", 5'h00, {3'h0, ten, crs});
        end
        half = 1'b1;
    endtask
    // Fill under stall; only the two buffered words survive, later refused
    task automatic t_rx;
        logic [4:0] exp [2] = '{`SYM_J, 5'h01};
        int n;
        for (int m = 0; m < 2; m++) begin
            {spd, sym, stall, n} = {2'b11 & {1'b1, m[0]}, 1'b1, 32'd0};
            tick(1);
            for (int k = 0; k < 5; k++) push(k == 0 ? `SYM_J : k[4:0]);
            rv = 1'b0;
            tick(3);
            chk("rx carrier", 5'h01, {4'h0, crs});
            chk("rx held", `SYM_J, rxd);
            stall = 1'b0;
            repeat (8) begin
                @(negedge clk);
                if (rxdv === 1'b1 && rdy === 1'b1)
                    chk("rx", exp[n++], rxd);
            end
            chk("rx count", 5'h02, n[4:0]);
            tick(1);
            push(`SYM_T);
            {rv, rd} = {1'b0, ~rd};
            tick(6);
            chk("rx carrier off", 5'h00, {4'h0, crs});
        end
    endtask
    // Start symbol arrives while sending, then reset pin mid-run
    task automatic t_col_rst;
        {spd, sym, send} = 3'b101;
        tick(7);
        push(`SYM_J);
        rv = 1'b0;
        tick(3);
        chk("collision", 5'h01, {4'h0, col});
        push(`SYM_T);
        rv = 1'b0;
        tick(6);
        send = 1'b0;
        tick(7);
        chk("idle", 5'h00, {3'h0, col, crs});
        req = 1'b1;
        tick(1);
        req = 1'b0;
        tick(5);
        chk("reset", 5'h02, {3'h0, iso, idone});
        wait_init();
    endtask
    initial begin
        tick(12);
        rst_b = 1'b1;
        tick(10);
        chk("init early", 5'h00, {4'h0, idone});
        wait_init();
        t_tx();
        t_rx();
        t_col_rst();
        complete_run();
    end
endmodule
`default_nettype wire

// File: test/phy_timing_checker.sv
`timescale 1ns/1ps
`include "phy_timing_regs.vh"
`default_nettype none
// ----
// Port timing checks
// ----
module phy_timing_checker (
    input wire       SYS_CLK,
    input wire       RST_B,
    input wire       HW_RESET_LOW_INPUT,
    input wire       HALF_DUPLEX,
    input wire       TXEN,
    input wire       LINE_RECEIVE_PAIR_VALID,
    input wire [4:0] LINE_RECEIVE_PAIR,
    input wire       LINE_TRANSMIT_PAIR_EN,
    input wire       RXDV,
    input wire [4:0] RXD,
    input wire       CRS,
    input wire       COL,
    input wire       ISOLATE,
    input wire       TXCLK_VALID,
    input wire       INIT_DONE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    // Word the core must take: output slot empty and core live
    wire take = LINE_RECEIVE_PAIR_VALID && !RXDV && INIT_DONE && !ISOLATE;
    wire tj   = take && LINE_RECEIVE_PAIR == `SYM_J;
    wire tt   = take && LINE_RECEIVE_PAIR == `SYM_T;
    a_tx_start: assert property ($rose(TXEN) && INIT_DONE
        |-> ##[3:4] LINE_TRANSMIT_PAIR_EN) else $error("tx start late");
    a_crs_tx_on: assert property ($rose(TXEN) && HALF_DUPLEX
        && INIT_DONE |-> ##[3:5] CRS) else $error("tx carrier late");
    a_crs_tx_off: assert property ($fell(TXEN) && HALF_DUPLEX && !COL
        |-> ##[3:5] !CRS) else $error("tx carrier held");
    a_rx_first: assert property (take
        |=> RXDV && RXD == $past(LINE_RECEIVE_PAIR)) else $error("rx word");
    a_crs_rx_on: assert property (tj |-> ##[2:4] CRS)
        else $error("rx carrier late");
    a_col_on: assert property (tj && LINE_TRANSMIT_PAIR_EN && HALF_DUPLEX
        |-> ##[2:4] COL) else $error("collision late");
    a_crs_rx_off: assert property (tt && !TXEN && !LINE_TRANSMIT_PAIR_EN
        |-> ##[3:5] !CRS) else $error("rx carrier held");
    a_reset_isolates: assert property ($fell(HW_RESET_LOW_INPUT)
        |-> ##[2:4] ISOLATE && !INIT_DONE && !TXCLK_VALID)
        else $error("isolate");
endmodule
bind phy_timing phy_timing_checker chk (.SYS_CLK, .RST_B, .HW_RESET_LOW_INPUT,
    .HALF_DUPLEX, .TXEN, .LINE_RECEIVE_PAIR_VALID, .LINE_RECEIVE_PAIR,
    .LINE_TRANSMIT_PAIR_EN, .RXDV, .RXD, .CRS, .COL, .ISOLATE, .TXCLK_VALID,
    .INIT_DONE);
`default_nettype wire
